// ---- dv/tb_top.sv ----
// Self-checking bench for the timer, event counter and divider output
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam logic [1:0] A_CTL = tmr_pkg::OFS_CTRL;
   localparam logic [1:0] A_CNT = tmr_pkg::OFS_COUNT;
   localparam logic [1:0] A_INT = tmr_pkg::OFS_INTCTL;
   localparam logic [1:0] A_PO  = tmr_pkg::OFS_PINOPT;
   logic        clk;
   logic        rst_n;
   logic        ce;
   logic [1:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic        cmp_in;
   logic        bypass;
   logic        pwr_dn;
   logic        gpio_out;
   logic        gpio_oe;
   logic        drv_en;
   logic        drv_val;
   logic        pin;
   logic        sh_o;
   logic        sh_oe;
   logic        div_out;
   logic [3:0]  od_sel;
   logic        irq;
   logic        wake;
   logic [15:0] tog;
   logic [15:0] wake_cnt;
   logic [7:0]  v;
   int          errors;
   int          cmp_count;

   tmr_event_counter tmr_event_counter_i (
      .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .timer_pin_in(pin),
      .comparator_event_in(cmp_in), .filter_bypass(bypass),
      .power_down(pwr_dn), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .divider_shared_pin_o(sh_o), .divider_shared_pin_oe(sh_oe),
      .freq_divider_out(div_out), .open_drain_sel(od_sel),
      .timer_irq(irq), .wake_up(wake));

   tmr_pin_model tmr_pin_model_i (
      .clk(clk), .rst_n(rst_n), .drive_en(drv_en), .drive_val(drv_val),
      .shared_pin_o(sh_o), .shared_pin_oe(sh_oe), .pin_level(pin),
      .toggle_cnt(tog));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_cnt <= 16'h0000;
      end else if (wake === 1'b1) begin
         wake_cnt <= wake_cnt + 16'h0001;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic lvl(input bit sel_pin, input logic val);
      @(posedge clk);
      if (sel_pin) drv_val <= val;
      else cmp_in <= val;
      repeat (6) @(posedge clk);
   endtask

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic t_regs;
      rd_reg(A_CTL, v);
      chk(v, tmr_pkg::CTRL_RST);
      rd_reg(A_PO, v);
      chk(v, tmr_pkg::PO_RST);
      wr_reg(A_PO, 8'hFF);
      rd_reg(A_PO, v);
      chk(v, 8'hF1);
      chk(od_sel, 4'hF);
      wr_reg(A_PO, 8'h00);
      repeat (3) @(posedge clk);
      chk({sh_oe, sh_o, div_out}, 3'b010);
      $display("test regs done");
   endtask

   task automatic div_rate(input logic [7:0] pre, input logic [2:0] psc,
                           input logic [15:0] exp);
      logic [15:0] t0;
      wr_reg(A_CNT, pre);
      wr_reg(A_CTL, {5'b1000_0, psc});
      wr_reg(A_CTL, {5'b1001_0, psc});
      repeat (10) @(posedge clk);
      chk(div_out, 1'b0);
      wr_reg(A_PO, 8'h01);
      repeat (300) @(posedge clk);
      chk(sh_oe, 1'b1);
      t0 = tog;
      repeat (1024) @(posedge clk);
      chk(tog - t0, exp);
      wr_reg(A_PO, 8'h00);
      wr_reg(A_CTL, 8'h80);
   endtask

   task automatic t_divider;
      for (int p = 0; p < 8; p++) begin
         div_rate(8'hFF, p[2:0], 16'(1024 >> p));
      end
      div_rate(8'hFC, 3'h0, 16'h0100);
      $display("test divider done");
   endtask

   task automatic t_irq;
      logic [7:0] c0;
      wr_reg(A_INT, 8'h01);
      wr_reg(A_CNT, 8'hFC);
      wr_reg(A_CTL, 8'h90);
      repeat (6) @(posedge clk);
      chk(irq, 1'b1);
      wr_reg(A_CTL, 8'h80);
      wr_reg(A_INT, 8'h01);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      rd_reg(A_CNT, c0);
      repeat (20) @(posedge clk);
      rd_reg(A_CNT, v);
      chk(v, c0);
      wr_reg(A_INT, 8'h00);
      wr_reg(A_CTL, 8'h90);
      repeat (5) @(posedge clk);
      wr_reg(A_CTL, 8'h80);
      chk(irq, 1'b0);
      rd_reg(A_INT, v);
      chk(v, 8'h02);
      $display("test irq done");
   endtask

   task automatic t_wake;
      logic [15:0] w0;
      pwr_dn <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         wr_reg(A_INT, s ? 8'h02 : 8'h00);
         w0 = wake_cnt;
         wr_reg(A_CTL, 8'h90);
         repeat (30) @(posedge clk);
         wr_reg(A_CTL, 8'h80);
         chk(wake_cnt - w0, s ? 16'h0000 : 16'h0001);
      end
      pwr_dn <= 1'b0;
      $display("test wake done");
   endtask

   task automatic t_ce;
      wr_reg(A_CNT, 8'h00);
      wr_reg(A_CTL, 8'h80);
      wr_reg(A_CTL, 8'h90);
      ce <= 1'b0;
      repeat (50) @(posedge clk);
      ce <= 1'b1;
      wr_reg(A_CTL, 8'h80);
      rd_reg(A_CNT, v);
      chk(v, 8'h02);
      $display("test clock enable done");
   endtask

   task automatic t_event;
      bypass <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         for (int te = 0; te < 2; te++) begin
            lvl(1'b1, 1'b1);
            lvl(1'b0, 1'b1);
            wr_reg(A_CNT, 8'h00);
            wr_reg(A_CTL, {1'b0, m[0], 2'b00, te[0], 3'b000});
            wr_reg(A_CTL, {1'b0, m[0], 2'b01, te[0], 3'b000});
            for (int k = 0; k < 5; k++) lvl(m[0], k[0]);
            wr_reg(A_CTL, 8'h00);
            rd_reg(A_CNT, v);
            chk(v, te ? 8'h03 : 8'h02);
         end
      end
      bypass <= 1'b0;
      wr_reg(A_CNT, 8'h00);
      wr_reg(A_CTL, 8'h40);
      wr_reg(A_CTL, 8'h50);
      @(posedge clk);
      drv_val <= 1'b1;
      @(posedge clk);
      drv_val <= 1'b0;
      repeat (6) @(posedge clk);
      lvl(1'b1, 1'b1);
      wr_reg(A_CTL, 8'h40);
      rd_reg(A_CNT, v);
      chk(v, 8'h01);
      $display("test event done");
   endtask

   task automatic t_capture;
      logic [7:0] c0;
      logic [7:0] cfg;
      bypass <= 1'b1;
      for (int e = 0; e < 2; e++) begin
         cfg = {4'b1100, e[0], 3'b000};
         lvl(1'b1, !e[0]);
         wr_reg(A_CNT, 8'h00);
         wr_reg(A_CTL, cfg);
         wr_reg(A_CTL, cfg | 8'h10);
         repeat (4) @(posedge clk);
         for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            drv_val <= e[0];
            repeat (20) @(posedge clk);
            drv_val <= !e[0];
            repeat (10) @(posedge clk);
            rd_reg(A_CTL, v);
            chk(v, cfg);
            rd_reg(A_CNT, v);
            if (p == 0) c0 = v;
            chk(v, c0);
         end
         chk(16'((c0 >= 8'h11) && (c0 <= 8'h17)), 16'h0001);
      end
      $display("test capture done");
   endtask

   initial begin
      rst_n    = 1'b0;
      ce       = 1'b1;
      addr     = 2'h0;
      wdata    = 8'h00;
      wr       = 1'b0;
      rd       = 1'b0;
      cmp_in   = 1'b1;
      bypass   = 1'b1;
      pwr_dn   = 1'b0;
      gpio_out = 1'b1;
      gpio_oe  = 1'b0;
      drv_en   = 1'b1;
      drv_val  = 1'b1;
      errors   = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_divider();
      t_irq();
      t_wake();
      t_ce();
      t_event();
      t_capture();
      final_report();
   end

   initial begin
      #120_000;
      errors++;
      $display("Watchdog expired at t=%0t", $time);
      final_report();
   end
endmodule
`default_nettype wire

// ---- dv/tmr_pin_model.sv ----
// Far-side model: external timer pin driver and divider pin monitor
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        drive_en,
   input  wire logic        drive_val,
   input  wire logic        shared_pin_o,
   input  wire logic        shared_pin_oe,
   output logic             pin_level,
   output logic [15:0]      toggle_cnt
);
   logic last_r;
   // Released pin rests at its pull-high level
   assign pin_level = drive_en ? drive_val : 1'b1;
   // Counts level changes on the divider pin while it is driven
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_r     <= 1'b0;
         toggle_cnt <= 16'h0000;
      end else begin
         last_r <= shared_pin_o;
         if (shared_pin_oe && (shared_pin_o != last_r)) begin
            toggle_cnt <= toggle_cnt + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// ---- include/tmr_pkg.sv ----
// Constants shared by the timer, event counter and divider output
package tmr_pkg;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned ADDR_W      = 2;
   localparam int unsigned PSC_W       = 7;
   // Register offsets
   localparam logic [1:0] OFS_CTRL     = 2'h0;
   localparam logic [1:0] OFS_COUNT    = 2'h1;
   localparam logic [1:0] OFS_INTCTL   = 2'h2;
   localparam logic [1:0] OFS_PINOPT   = 2'h3;
   // Timer control fields
   localparam int unsigned CTRL_MODE_HI = 7;
   localparam int unsigned CTRL_MODE_LO = 6;
   localparam int unsigned CTRL_RUN     = 4;
   localparam int unsigned CTRL_EDGE    = 3;
   localparam int unsigned CTRL_PSC_HI  = 2;
   localparam int unsigned CTRL_PSC_LO  = 0;
   localparam logic [7:0]  CTRL_RST     = 8'h08;
   localparam logic [7:0]  CTRL_RD_MASK = 8'hDF;
   // Interrupt control fields
   localparam int unsigned INT_EN_BIT   = 0;
   localparam int unsigned INT_FLAG_BIT = 1;
   // Pin option fields
   localparam int unsigned PO_DIV_EN    = 0;
   localparam int unsigned PO_OD_HI     = 7;
   localparam int unsigned PO_OD_LO     = 4;
   localparam logic [7:0]  PO_RST       = 8'h00;
   localparam logic [7:0]  PO_RD_MASK   = 8'hF1;
   // Counter values
   localparam logic [7:0]  CNT_FULL     = 8'hFF;
   localparam logic [7:0]  ZERO8        = 8'h00;
   // Operating modes
   localparam logic [1:0]  MODE_CMP     = 2'h0;
   localparam logic [1:0]  MODE_PIN     = 2'h1;
   localparam logic [1:0]  MODE_TIMER   = 2'h2;
   localparam logic [1:0]  MODE_CAPT    = 2'h3;
   // Pulse capture states
   typedef enum logic [2:0] {
      CAP_IDLE  = 3'b001,
      CAP_ARMED = 3'b010,
      CAP_MEAS  = 3'b100
   } cap_state_t;
endpackage

// ---- include/tmr_tick_if.sv ----
// Carrier between the timer core, its prescaler and its pin filter
`timescale 1ns/10ps
`default_nettype none
interface tmr_tick_if;
   logic [2:0] psc_sel;
   logic       tick;
   logic       pin_raw;
   logic       bypass;
   logic       pin_filt;
   modport core      (output psc_sel, pin_raw, bypass,
                      input  tick, pin_filt);
   modport prescaler (input  psc_sel, output tick);
   modport filter    (input  pin_raw, bypass, output pin_filt);
endinterface
`default_nettype wire

// ---- logic/tmr_event_counter.sv ----
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module tmr_event_counter (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       timer_pin_in,
   input  wire logic       comparator_event_in,
   input  wire logic       filter_bypass,
   input  wire logic       power_down,
   input  wire logic       gpio_out,
   input  wire logic       gpio_oe,
   output logic            divider_shared_pin_o,
   output logic            divider_shared_pin_oe,
   output logic            freq_divider_out,
   output logic      [3:0] open_drain_sel,
   output logic            timer_irq,
   output logic            wake_up
);
   tmr_tick_if tk ();

   logic [7:0]         ctrl_r;
   logic [7:0]         preload_r;
   logic [7:0]         count_r;
   logic [7:0]         pin_opt_r;
   logic               int_en_r;
   logic               flag_r;
   logic               pfd_r;
   logic               cmp_prev_r;
   logic               pin_prev_r;
   logic [7:0]         rdata_r;
   logic               irq_r;
   logic               wake_r;
   logic               pin_o_r;
   logic               pin_oe_r;
   tmr_pkg::cap_state_t cap_st_r;
   tmr_pkg::cap_state_t cap_st_nxt;

   logic [1:0] mode;
   logic       run;
   logic       edge_sel;
   logic       div_en;
   logic       wr_ctrl;
   logic       wr_cnt;
   logic       rd_cnt;
   logic       wr_int;
   logic       wr_po;
   logic       inhibit;
   logic       cmp_edge;
   logic       pin_edge;
   logic       act_lvl;
   logic       cap_start;
   logic       cap_end;
   logic       src_tick;
   logic       advance;
   logic       ovf;

   tmr_prescaler u_psc (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .tk    (tk.prescaler)
   );

   tmr_pin_filter u_filt (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .tk    (tk.filter)
   );

   assign mode     = ctrl_r[tmr_pkg::CTRL_MODE_HI:tmr_pkg::CTRL_MODE_LO];
   assign run      = ctrl_r[tmr_pkg::CTRL_RUN];
   assign edge_sel = ctrl_r[tmr_pkg::CTRL_EDGE];
   assign div_en   = pin_opt_r[tmr_pkg::PO_DIV_EN];
   assign tk.psc_sel = ctrl_r[tmr_pkg::CTRL_PSC_HI:tmr_pkg::CTRL_PSC_LO];
   assign tk.pin_raw = timer_pin_in;
   assign tk.bypass  = filter_bypass;

   assign wr_ctrl = wr && (addr == tmr_pkg::OFS_CTRL);
   assign wr_cnt  = wr && (addr == tmr_pkg::OFS_COUNT);
   assign rd_cnt  = rd && (addr == tmr_pkg::OFS_COUNT);
   assign wr_int  = wr && (addr == tmr_pkg::OFS_INTCTL);
   assign wr_po   = wr && (addr == tmr_pkg::OFS_PINOPT);
   assign inhibit = rd_cnt || wr_cnt;

   // Edge detection: select 0 rising, 1 falling
   assign cmp_edge = edge_sel ? (cmp_prev_r && !comparator_event_in)
                              : (!cmp_prev_r && comparator_event_in);
   assign pin_edge = edge_sel ? (pin_prev_r && !tk.pin_filt)
                              : (!pin_prev_r && tk.pin_filt);
   // Capture: select 1 measures high pulse, 0 low pulse
   assign act_lvl   = edge_sel;
   assign cap_start = (cap_st_r == tmr_pkg::CAP_ARMED) &&
                      (tk.pin_filt == act_lvl) && (pin_prev_r != act_lvl);
   assign cap_end   = (cap_st_r == tmr_pkg::CAP_MEAS) &&
                      (tk.pin_filt != act_lvl);

   always_comb begin
      case (mode)
         tmr_pkg::MODE_CMP:   src_tick = cmp_edge;
         tmr_pkg::MODE_PIN:   src_tick = pin_edge;
         tmr_pkg::MODE_TIMER: src_tick = tk.tick;
         tmr_pkg::MODE_CAPT:  src_tick = tk.tick && !cap_end &&
                                         (cap_st_r == tmr_pkg::CAP_MEAS);
         default:             src_tick = 1'b0;
      endcase
   end

   assign advance = run && !inhibit && src_tick;
   assign ovf     = advance && (count_r == tmr_pkg::CNT_FULL);

   always_comb begin
      cap_st_nxt = cap_st_r;
      case (cap_st_r)
         tmr_pkg::CAP_IDLE: begin
            if (run && (mode == tmr_pkg::MODE_CAPT)) begin
               cap_st_nxt = tmr_pkg::CAP_ARMED;
            end
         end
         tmr_pkg::CAP_ARMED: begin
            if (!run || (mode != tmr_pkg::MODE_CAPT)) begin
               cap_st_nxt = tmr_pkg::CAP_IDLE;
            end else if (cap_start) begin
               cap_st_nxt = tmr_pkg::CAP_MEAS;
            end
         end
         tmr_pkg::CAP_MEAS: begin
            if (!run || (mode != tmr_pkg::MODE_CAPT) || cap_end) begin
               cap_st_nxt = tmr_pkg::CAP_IDLE;
            end
         end
         default: cap_st_nxt = tmr_pkg::CAP_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_st_r <= tmr_pkg::CAP_IDLE;
      end else if (ce) begin
         cap_st_r <= cap_st_nxt;
      end
   end

   // Pin and comparator history, sampled at each clock with ce high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_prev_r <= 1'b0;
         pin_prev_r <= 1'b0;
      end else if (ce) begin
         cmp_prev_r <= comparator_event_in;
         pin_prev_r <= tk.pin_filt;
      end
   end

   // Control register; capture end clears run, software write wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= tmr_pkg::CTRL_RST;
      end else if (ce) begin
         if (wr_ctrl) begin
            ctrl_r <= wdata & tmr_pkg::CTRL_RD_MASK;
         end else if (cap_end) begin
            ctrl_r[tmr_pkg::CTRL_RUN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         preload_r <= tmr_pkg::ZERO8;
      end else if (ce && wr_cnt) begin
         preload_r <= wdata;
      end
   end

   // Counter: loads preload while stopped, reloads on overflow
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= tmr_pkg::ZERO8;
      end else if (ce) begin
         if (wr_cnt && !run) begin
            count_r <= wdata;
         end else if (ovf) begin
            count_r <= preload_r;
         end else if (advance) begin
            count_r <= count_r + 8'h01;
         end
      end
   end

   // Interrupt enable and request flag; overflow beats a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_en_r <= 1'b0;
         flag_r   <= 1'b0;
      end else if (ce) begin
         if (wr_int) begin
            int_en_r <= wdata[tmr_pkg::INT_EN_BIT];
         end
         if (ovf) begin
            flag_r <= 1'b1;
         end else if (wr_int) begin
            flag_r <= wdata[tmr_pkg::INT_FLAG_BIT];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r  <= 1'b0;
         wake_r <= 1'b0;
      end else if (ce) begin
         irq_r  <= flag_r && int_en_r;
         wake_r <= ovf && power_down && !flag_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_opt_r <= tmr_pkg::PO_RST;
      end else if (ce && wr_po) begin
         pin_opt_r <= wdata & tmr_pkg::PO_RD_MASK;
      end
   end

   // Divider level: low while disabled, toggles on overflow
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pfd_r <= 1'b0;
      end else if (ce) begin
         if (!div_en) begin
            pfd_r <= 1'b0;
         end else if (ovf) begin
            pfd_r <= !pfd_r;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_o_r  <= 1'b0;
         pin_oe_r <= 1'b0;
      end else if (ce) begin
         pin_o_r  <= div_en ? pfd_r : gpio_out;
         pin_oe_r <= div_en ? 1'b1 : gpio_oe;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= tmr_pkg::ZERO8;
      end else if (ce) begin
         if (rd) begin
            case (addr)
               tmr_pkg::OFS_CTRL:   rdata_r <= ctrl_r;
               tmr_pkg::OFS_COUNT:  rdata_r <= count_r;
               tmr_pkg::OFS_INTCTL: rdata_r <= {6'h00, flag_r, int_en_r};
               tmr_pkg::OFS_PINOPT: rdata_r <= pin_opt_r;
               default:             rdata_r <= tmr_pkg::ZERO8;
            endcase
         end else begin
            rdata_r <= tmr_pkg::ZERO8;
         end
      end
   end

   assign rdata                 = rdata_r;
   assign divider_shared_pin_o  = pin_o_r;
   assign divider_shared_pin_oe = pin_oe_r;
   assign freq_divider_out      = pfd_r;
   assign open_drain_sel        = pin_opt_r[tmr_pkg::PO_OD_HI:tmr_pkg::PO_OD_LO];
   assign timer_irq             = irq_r;
   assign wake_up               = wake_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ovf_reload_a: assert property (ce && ovf |=> count_r == $past(preload_r))
      else $error("counter did not reload preload on overflow");
   div_toggle_a: assert property (ce && ovf && div_en |=> pfd_r != $past(pfd_r))
      else $error("divider output did not toggle on overflow");
   div_low_a: assert property (ce && !div_en |=> !pfd_r ##0 !freq_divider_out)
      else $error("divider level not low while disabled");
   flag_set_a: assert property (ce && ovf |=> flag_r)
      else $error("overflow did not set the request flag");
   irq_gate_a: assert property (ce ##1 ce |-> timer_irq == $past(flag_r && int_en_r))
      else $error("interrupt output not flag and enable");
   wake_set_a: assert property (ce && ovf && power_down && !flag_r |=> wake_up)
      else $error("overflow in power-down gave no wake-up");
   wake_block_a: assert property (ce && flag_r |=> !wake_up)
      else $error("wake-up despite preset request flag");
   read_hold_a: assert property (ce && rd_cnt |=> count_r == $past(count_r))
      else $error("counter moved during counter read");
   stop_hold_a: assert property (ce && !run && !wr_cnt |=> $stable(count_r))
      else $error("counter moved while stopped");
   cap_clear_a: assert property (ce && cap_end && !wr_ctrl |=> !run)
      else $error("capture end did not clear run");
   unimpl_zero_a: assert property (ce && rd && addr == tmr_pkg::OFS_PINOPT
                                   |=> rdata_r[3:1] == 3'h0)
      else $error("unimplemented pin option bits read nonzero");
   pin_route_a: assert property (ce ##1 ce && div_en && $stable(div_en)
                                 |-> divider_shared_pin_oe)
      else $error("divider enabled but pin not driven");

   timer_ovf_c: cover property (ce && ovf && mode == tmr_pkg::MODE_TIMER);
   capture_c:   cover property (ce && cap_end);
   wake_c:      cover property (ce && wake_r);
   pin_ovf_c:   cover property (ce && ovf && mode == tmr_pkg::MODE_PIN);
endmodule
`default_nettype wire

// ---- logic/tmr_pin_filter.sv ----
// Noise filter on the external timer pin, bypassable
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_filter (
   input  wire logic   clk,
   input  wire logic   rst_n,
   input  wire logic   ce,
   tmr_tick_if.filter  tk
);
   logic samp_r;
   logic filt_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_r <= 1'b0;
      end else if (ce) begin
         samp_r <= tk.pin_raw;
      end
   end

   // Level passes only after two equal samples unless bypassed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_r <= 1'b0;
      end else if (ce) begin
         if (tk.bypass || (samp_r == tk.pin_raw)) begin
            filt_r <= tk.pin_raw;
         end
      end
   end

   assign tk.pin_filt = filt_r;
endmodule
`default_nettype wire

// ---- logic/tmr_prescaler.sv ----
// Power-of-two prescaler for the timer clock
`timescale 1ns/10ps
`default_nettype none
module tmr_prescaler (
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire logic      ce,
   tmr_tick_if.prescaler  tk
);
   logic [tmr_pkg::PSC_W-1:0] div_r;
   logic [tmr_pkg::PSC_W-1:0] mask;
   logic                      tick_r;

   // Select 000 divides by one, 111 by 128
   assign mask = tmr_pkg::PSC_W'((8'h01 << tk.psc_sel) - 8'h01);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= '0;
      end else if (ce) begin
         div_r <= div_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_r <= 1'b0;
      end else if (ce) begin
         tick_r <= ((div_r & mask) == mask);
      end
   end

   assign tk.tick = tick_r;
endmodule
`default_nettype wire
